// >>> dcsr_bank.sv
/*
 Control and status register bank of the detector interface board.
 Takes decoded block-transfer commands, holds the control word and the
 error/source flags, and answers readback requests with a reply word.
 Assumes commands arrive on clk as one-cycle strobes from the frame
 decoder, the reply path accepts a word whenever reply_ready is high,
 and the mode state machine sits outside and reports its mode code.
*/
`timescale 1ns/10ps

`include "dcsr_params.svh"

// What this block does
// - 16-bit read/write control register, resets to zero, upper bits spare.
// - Prespill bit one: spill warning prepares ACTIVE, start expected at spill.
// - Prespill bit zero: no warning used; start command itself triggers prepare.
// - Readback command decoded at 0x0012; bits 15..2 read as zero.
// - Data 0x0002 requests status return; bit self-clears when sent.
// - Data 0x0001 requests control return; bit self-clears when sent.
// - 16-bit read-only status register, resets to zero, returned on request.
// - Status bits 12..9 carry the current mode code.
// - Status bit 8 flags a watchdog timeout.
// - Status bit 7 flags a supply voltage or current out of range.
// - Status bit 6 shows commands forwarded onto the chain link.
// - Status bit 5 shows chain link as command source.
// - Status bit 4 flags slow-control readback errors.
// - Status bit 3 flags overtemperature.
// - Status bit 2 flags a command refused while another runs.
// - Status bit 1 flags an unrecognised command.
// - Status bit 0 flags a frame checksum error.
// - Control written at 0x0010, read back through readback command.
module dcsr_bank (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire dcsr_pkg::dcsr_cmd_s  cmd,
	input  wire dcsr_pkg::dcsr_mode_e current_mode_code,
	input  wire dcsr_pkg::dcsr_events_s events,
	input  wire logic                 spill_warning,
	input  wire logic                 acquisition_start,
	input  wire logic                 reply_ready,
	output dcsr_pkg::dcsr_reply_s     reply,
	output logic [15:0]               board_control,
	output logic [15:0]               board_status_primary,
	output logic [1:0]                register_readback_command,
	output logic                      prespill_mode_select,
	output logic                      prepare_data_taking,
	output logic                      start_at_spill
);
	import dcsr_pkg::*;

	dcsr_state_s state_q;
	dcsr_state_s state_d;
	logic [15:0] status_word;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Flag with explicit set and clear; set wins over a same-cycle clear
	function automatic logic sticky(input logic cur, input logic set,
			input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	function automatic logic hit(input dcsr_cmd_s c, input logic [15:0] a);
		hit = c.valid && (c.type_modifier == a);
	endfunction

	// ------------------------------------------------------------
	// Status word assembly
	// ------------------------------------------------------------
	always_comb begin
		status_word = 16'h0000;
		status_word[`DCSR_ST_MODE_HI:`DCSR_ST_MODE_LO] =
			current_mode_code;
		status_word[`DCSR_ST_WATCHDOG_BIT]  = state_q.watchdog;
		status_word[`DCSR_ST_POWER_BIT]     = state_q.power;
		status_word[`DCSR_ST_CHAIN_FWD_BIT] = state_q.chain_fwd;
		status_word[`DCSR_ST_CHAIN_IN_BIT]  = state_q.chain_in;
		status_word[`DCSR_ST_SLOWCFG_BIT]   = state_q.slowcfg;
		status_word[`DCSR_ST_OVERTEMP_BIT]  = state_q.overtemp;
		status_word[`DCSR_ST_REJECT_BIT]    = state_q.reject;
		status_word[`DCSR_ST_UNKNOWN_BIT]   = state_q.unknown;
		status_word[`DCSR_ST_CHECKSUM_BIT]  = state_q.checksum;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;

		// Control write
		if (hit(cmd, `DCSR_ADDR_CONTROL_WRITE)) begin
			state_d.control = cmd.data;
		end

		// Readback requests; reserved data bits are dropped
		if (hit(cmd, `DCSR_ADDR_READBACK)) begin
			if (cmd.data[`DCSR_RB_CONTROL_BIT]) begin
				state_d.readback_req[`DCSR_RB_CONTROL_BIT] = 1'b1;
			end
			if (cmd.data[`DCSR_RB_STATUS_BIT]) begin
				state_d.readback_req[`DCSR_RB_STATUS_BIT] = 1'b1;
			end
		end

		// Conditions that are live levels
		state_d.power     = events.power_fault;
		state_d.chain_fwd = events.chain_forward;
		state_d.chain_in  = events.chain_input;
		state_d.overtemp  = events.overtemp;

		// Event flags hold until a success report of the same kind
		state_d.watchdog = sticky(state_q.watchdog,
			events.watchdog_fired, events.watchdog_ok);
		state_d.slowcfg  = sticky(state_q.slowcfg,
			events.slow_config_bad, events.slow_config_good);
		state_d.reject   = sticky(state_q.reject,
			events.cmd_rejected, events.cmd_accepted);
		state_d.unknown  = sticky(state_q.unknown,
			events.cmd_unknown, events.cmd_known);
		state_d.checksum = sticky(state_q.checksum,
			events.frame_bad, events.frame_good);

		// Reply sequencer; one word per request, control before status
		state_d.reply.valid = state_q.reply.valid & ~reply_ready;
		case (state_q.rb_state)
			DCSR_RB_IDLE: begin
				if (state_q.readback_req[`DCSR_RB_CONTROL_BIT]) begin
					state_d.rb_state = DCSR_RB_SEND_CONTROL;
				end else if (state_q.readback_req[`DCSR_RB_STATUS_BIT]) begin
					state_d.rb_state = DCSR_RB_SEND_STATUS;
				end
			end
			DCSR_RB_SEND_CONTROL: begin
				if (!state_q.reply.valid || reply_ready) begin
					state_d.reply.valid = 1'b1;
					state_d.reply.type_modifier = `DCSR_ADDR_CONTROL_WRITE;
					state_d.reply.data = state_q.control;
					// Clear wins only if no fresh request landed now
					if (!(hit(cmd, `DCSR_ADDR_READBACK) &&
							cmd.data[`DCSR_RB_CONTROL_BIT])) begin
						state_d.readback_req[`DCSR_RB_CONTROL_BIT] =
							1'b0;
					end
					state_d.rb_state = DCSR_RB_IDLE;
				end
			end
			DCSR_RB_SEND_STATUS: begin
				if (!state_q.reply.valid || reply_ready) begin
					state_d.reply.valid = 1'b1;
					state_d.reply.type_modifier = `DCSR_ADDR_READBACK;
					state_d.reply.data = status_word;
					if (!(hit(cmd, `DCSR_ADDR_READBACK) &&
							cmd.data[`DCSR_RB_STATUS_BIT])) begin
						state_d.readback_req[`DCSR_RB_STATUS_BIT] =
							1'b0;
					end
					state_d.rb_state = DCSR_RB_IDLE;
				end
			end
			default: begin
				state_d.rb_state = DCSR_RB_IDLE;
			end
		endcase

		// Acquisition preparation scheme
		state_d.expect_start = 1'b0;
		if (state_q.control[`DCSR_CTRL_PRESPILL_BIT]) begin
			if (spill_warning) begin
				state_d.prepare = 1'b1;
			end
			if (acquisition_start) begin
				state_d.expect_start = 1'b1;
				state_d.prepare = 1'b0;
			end
		end else begin
			// Warning ignored; start arrives well before the spill
			if (acquisition_start) begin
				state_d.prepare = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q.control      <= `DCSR_CTRL_RESET;
			state_q.readback_req <= `DCSR_RB_RESET;
			state_q.rb_state     <= DCSR_RB_IDLE;
			state_q.watchdog     <= 1'b0;
			state_q.power        <= 1'b0;
			state_q.chain_fwd    <= 1'b0;
			state_q.chain_in     <= 1'b0;
			state_q.slowcfg      <= 1'b0;
			state_q.overtemp     <= 1'b0;
			state_q.reject       <= 1'b0;
			state_q.unknown      <= 1'b0;
			state_q.checksum     <= 1'b0;
			state_q.reply        <= '0;
			state_q.prepare      <= 1'b0;
			state_q.expect_start <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	// Status is registered once more so the port stays a flop output
	logic [15:0] status_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= `DCSR_STATUS_RESET;
		end else begin
			status_q <= status_word;
		end
	end

	assign reply                     = state_q.reply;
	assign board_control             = state_q.control;
	assign board_status_primary      = status_q;
	assign register_readback_command = state_q.readback_req;
	assign prespill_mode_select      = state_q.control[`DCSR_CTRL_PRESPILL_BIT];
	assign prepare_data_taking       = state_q.prepare;
	assign start_at_spill            = state_q.expect_start;

endmodule

// >>> dcsr_params.svh
/*
 Constants for the detector control/status register bank: command
 addresses, request codes, field positions and reset values.
 Assumes inclusion by bare name from the package and the bank module.
*/
`ifndef DCSR_PARAMS_SVH
`define DCSR_PARAMS_SVH

// ------------------------------------------------------------
// Command addresses (block-transfer type modifier)
// ------------------------------------------------------------
`define DCSR_ADDR_CONTROL_WRITE 16'h0010
`define DCSR_ADDR_READBACK      16'h0012

// ------------------------------------------------------------
// Readback request fields and data codes
// ------------------------------------------------------------
`define DCSR_RB_CONTROL_BIT     0
`define DCSR_RB_STATUS_BIT      1
`define DCSR_RB_FETCH_CONTROL   16'h0001
`define DCSR_RB_FETCH_STATUS    16'h0002

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define DCSR_CTRL_PRESPILL_BIT  0

// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
`define DCSR_ST_MODE_HI         12
`define DCSR_ST_MODE_LO         9
`define DCSR_ST_WATCHDOG_BIT    8
`define DCSR_ST_POWER_BIT       7
`define DCSR_ST_CHAIN_FWD_BIT   6
`define DCSR_ST_CHAIN_IN_BIT    5
`define DCSR_ST_SLOWCFG_BIT     4
`define DCSR_ST_OVERTEMP_BIT    3
`define DCSR_ST_REJECT_BIT      2
`define DCSR_ST_UNKNOWN_BIT     1
`define DCSR_ST_CHECKSUM_BIT    0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DCSR_CTRL_RESET         16'h0000
`define DCSR_STATUS_RESET       16'h0000
`define DCSR_RB_RESET           2'h0

`endif

// >>> dcsr_pkg.sv
/*
 Types shared by the detector control/status register bank.
 Assumes the _params header sits in the same folder.
*/
package dcsr_pkg;

	`include "dcsr_params.svh"

	typedef enum logic [3:0] {
		DCSR_MODE_SLEEP     = 4'h0,
		DCSR_MODE_IDLE      = 4'h1,
		DCSR_MODE_SYNC      = 4'h2,
		DCSR_MODE_LOOP      = 4'h3,
		DCSR_MODE_ACTIVE    = 4'h4,
		DCSR_MODE_READOUT   = 4'h5,
		DCSR_MODE_CONFIG    = 4'h6,
		DCSR_MODE_DEBUG     = 4'h7,
		DCSR_MODE_CALIBRATE = 4'h8,
		DCSR_MODE_ERROR     = 4'hF
	} dcsr_mode_e;

	// Incoming block-transfer command word
	typedef struct packed {
		logic        valid;
		logic [15:0] type_modifier;
		logic [15:0] data;
	} dcsr_cmd_s;

	// Word returned to the aggregator
	typedef struct packed {
		logic        valid;
		logic [15:0] type_modifier;
		logic [15:0] data;
	} dcsr_reply_s;

	// Event and condition inputs from the rest of the board
	typedef struct packed {
		logic       watchdog_fired;
		logic       watchdog_ok;
		logic       power_fault;
		logic       chain_forward;
		logic       chain_input;
		logic       slow_config_bad;
		logic       slow_config_good;
		logic       overtemp;
		logic       cmd_rejected;
		logic       cmd_accepted;
		logic       cmd_unknown;
		logic       cmd_known;
		logic       frame_bad;
		logic       frame_good;
	} dcsr_events_s;

	typedef enum logic [1:0] {
		DCSR_RB_IDLE,
		DCSR_RB_SEND_CONTROL,
		DCSR_RB_SEND_STATUS
	} dcsr_rb_state_e;

	typedef struct packed {
		logic [15:0]    control;
		logic [1:0]     readback_req;
		dcsr_rb_state_e rb_state;
		logic           watchdog;
		logic           power;
		logic           chain_fwd;
		logic           chain_in;
		logic           slowcfg;
		logic           overtemp;
		logic           reject;
		logic           unknown;
		logic           checksum;
		dcsr_reply_s    reply;
		logic           prepare;
		logic           expect_start;
	} dcsr_state_s;

endpackage

// >>> dcsr_bank_chk.sv
/*
 Port checker for the register bank.
 Assumes a bind from the bench top file.
*/
`timescale 1ns/10ps
module dcsr_bank_chk (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire dcsr_pkg::dcsr_cmd_s    cmd,
	input wire dcsr_pkg::dcsr_mode_e   current_mode_code,
	input wire dcsr_pkg::dcsr_events_s events,
	input wire logic                   spill_warning,
	input wire logic                   acquisition_start,
	input wire logic                   reply_ready,
	input wire dcsr_pkg::dcsr_reply_s  reply,
	input wire logic [15:0]            board_control,
	input wire logic [15:0]            board_status_primary,
	input wire logic                   prespill_mode_select,
	input wire logic                   prepare_data_taking,
	input wire logic                   start_at_spill
);
	import dcsr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_ctl_wr;
		cmd.valid && cmd.type_modifier == 16'h0010
		|=> board_control == $past(cmd.data);
	endproperty
	a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
	property p_rb_st;
		cmd.valid && cmd.type_modifier == 16'h0012 && cmd.data[1]
		|-> ##[3:20] reply.valid && reply.type_modifier == 16'h0012;
	endproperty
	a_rb_st: assert property (p_rb_st) else $error("no status reply");
	property p_rb_ctl;
		cmd.valid && cmd.type_modifier == 16'h0012 && cmd.data[0]
		|-> ##[3:20] reply.valid && reply.type_modifier == 16'h0010;
	endproperty
	a_rb_ctl: assert property (p_rb_ctl) else $error("no control reply");
	property p_hold;
		reply.valid && !reply_ready |=> reply.valid && $stable(reply.data);
	endproperty
	a_hold: assert property (p_hold) else $error("reply dropped");
	property p_top;
		board_status_primary[15:13] == 3'h0;
	endproperty
	a_top: assert property (p_top) else $error("spare status bits set");
	property p_mode;
		!$past(rst, 2) && $stable(current_mode_code)
		&& $past(current_mode_code, 2) == current_mode_code
		|-> board_status_primary[12:9] == current_mode_code;
	endproperty
	a_mode: assert property (p_mode) else $error("mode field wrong");
	property p_warn;
		prespill_mode_select && spill_warning |=> prepare_data_taking;
	endproperty
	a_warn: assert property (p_warn) else $error("warning not taken");
	property p_start1;
		prespill_mode_select && acquisition_start
		|=> start_at_spill && !prepare_data_taking;
	endproperty
	a_start1: assert property (p_start1) else $error("start pulse bad");
	property p_start0;
		!prespill_mode_select && acquisition_start
		|=> prepare_data_taking && !start_at_spill;
	endproperty
	a_start0: assert property (p_start0) else $error("start prep bad");
	property p_crc;
		events.frame_bad |-> ##2 board_status_primary[0];
	endproperty
	a_crc: assert property (p_crc) else $error("checksum flag late");
endmodule

// >>> dcsr_agg_model.sv
/*
 Aggregator model: sink of reply words, able to stall.
 Assumes stall is driven just after a clock edge.
*/
`timescale 1ns/10ps
module dcsr_agg_model (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire dcsr_pkg::dcsr_reply_s reply,
	input  wire logic                  stall,
	output logic                       reply_ready,
	output dcsr_pkg::dcsr_reply_s      last_word,
	output logic [7:0]                 word_count
);
	import dcsr_pkg::*;
	always @(posedge clk) begin
		if (rst) begin
			reply_ready <= 1'b0;
			word_count  <= 8'h00;
			last_word   <= '0;
		end else begin
			// Word taken only on an edge with ready high
			if (reply.valid && reply_ready) begin
				last_word  <= reply;
				word_count <= word_count + 8'h01;
			end
			reply_ready <= !stall;
		end
	end
endmodule

// >>> dcsr_bank_test.sv
/*
 Bench for the register bank: command tasks, mode and flag tables.
 Assumes the bank, its checker and the aggregator model.
*/
`timescale 1ns/10ps
module dcsr_bank_test;
	import dcsr_pkg::*;
	logic        clk = 0, rst = 1, stall = 0, rdy, psel, prep, sas;
	logic [1:0]  sa = 2'h0, rbc;
	logic [13:0] ev = '0;
	logic [15:0] ctl, st;
	logic [7:0]  cnt;
	dcsr_cmd_s   cmd = '0;
	dcsr_mode_e  mode = DCSR_MODE_SLEEP;
	dcsr_reply_s rep, got;
	int          bad_count = 0, num_checks = 0;
	logic [3:0]  mc [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15};
	// Status bit, set event, clear event (14 means level, none)
	logic [3:0]  fb [9] = '{8, 7, 6, 5, 4, 3, 2, 1, 0};
	logic [3:0]  fs [9] = '{13, 11, 10, 9, 8, 6, 5, 3, 1};
	logic [3:0]  fc [9] = '{12, 14, 14, 14, 7, 14, 4, 2, 0};
	always #5 clk = ~clk;
	dcsr_bank dut (.clk(clk), .rst(rst), .cmd(cmd), .current_mode_code(mode),
		.events(dcsr_events_s'(ev)), .spill_warning(sa[0]),
		.acquisition_start(sa[1]), .reply_ready(rdy), .reply(rep),
		.board_control(ctl), .board_status_primary(st),
		.register_readback_command(rbc), .prespill_mode_select(psel),
		.prepare_data_taking(prep), .start_at_spill(sas));
	dcsr_agg_model agg (.clk(clk), .rst(rst), .reply(rep), .stall(stall),
		.reply_ready(rdy), .last_word(got), .word_count(cnt));
	// ----
	// Tasks
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		cmd <= '{1'b1, a, d};
		@(posedge clk);
		cmd <= '0;
		#1;
	endtask
	task automatic pulse(input int w);
		@(posedge clk);
		sa[w] <= 1'b1;
		@(posedge clk);
		sa[w] <= 1'b0;
		#1;
	endtask
	// Bounded wait; a hang ends the run as a failure
	// Count is read once settled after each edge, so a word taken on the
	// next edge cannot overwrite the one just waited for
	task automatic wait_word(input logic [7:0] n);
		for (int i = 0; i < 40 && cnt !== n; i++) begin
			@(posedge clk);
			#1;
		end
		if (cnt !== n) begin
			bad_count++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [15:0] d, tm, exp);
		logic [7:0] n;
		n = cnt + 8'h01;
		send(16'h0012, d);
		wait_word(n);
		check(got.type_modifier, tm);
		check(got.data, exp);
		check({14'h0, rbc}, 16'h0000);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		logic [7:0] n;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		check(ctl, 16'h0000);
		check(st, 16'h0000);
		check({14'h0, rbc}, 16'h0000);
		send(16'h0010, 16'hA5A5);
		check(ctl, 16'hA5A5);
		check({15'h0, psel}, 16'h0001);
		rd(16'h0001, 16'h0010, 16'hA5A5);
		n = cnt;
		send(16'h0014, 16'h1234);
		send(16'h0012, 16'hFFFC);
		cyc(8);
		check(ctl, 16'hA5A5);
		check({6'h0, cnt, rbc}, {6'h0, n, 2'h0});
		for (int i = 0; i < 10; i++) begin
			@(posedge clk) mode <= dcsr_mode_e'(mc[i]);
			cyc(3);
			rd(16'h0002, 16'h0012, {3'h0, mc[i], 9'h0});
		end
		@(posedge clk) mode <= DCSR_MODE_SLEEP;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk) ev <= 14'(15'h1 << fs[i]);
			@(posedge clk);
			if (fc[i] != 4'hE) ev <= '0;
			cyc(3);
			check(st, 16'h1 << fb[i]);
			@(posedge clk) ev <= 14'(15'h1 << fc[i]);
			cyc(3);
			check(st, 16'h0000);
			@(posedge clk) ev <= '0;
		end
		n = cnt;
		@(posedge clk) stall <= 1'b1;
		send(16'h0012, 16'h0003);
		cyc(8);
		check({14'h0, rbc}, 16'h0002);
		@(posedge clk) stall <= 1'b0;
		wait_word(n + 8'h01);
		check(got.type_modifier, 16'h0010);
		wait_word(n + 8'h02);
		check(got.type_modifier, 16'h0012);
		pulse(0);
		check({15'h0, prep}, 16'h0001);
		pulse(1);
		check({14'h0, sas, prep}, 16'h0002);
		send(16'h0010, 16'h0000);
		pulse(0);
		check({15'h0, prep}, 16'h0000);
		pulse(1);
		check({14'h0, sas, prep}, 16'h0001);
		end_of_test();
	end
	initial begin
		repeat (50000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
bind dcsr_bank dcsr_bank_chk chk (.clk(clk), .rst(rst), .cmd(cmd),
	.current_mode_code(current_mode_code), .events(events),
	.spill_warning(spill_warning), .acquisition_start(acquisition_start),
	.reply_ready(reply_ready), .reply(reply), .board_control(board_control),
	.board_status_primary(board_status_primary),
	.prespill_mode_select(prespill_mode_select),
	.prepare_data_taking(prepare_data_taking),
	.start_at_spill(start_at_spill));
